// *** design/adc_converter_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_converter_end
  import adc_link_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  adc_spi_if.converter                spi,
  input  wire logic [RESULT_BITS-1:0] sample_value,
  output logic                        sample_take,
  output logic      [CHAN_BITS:0]     sample_config
);

  typedef enum logic [1:0] {st_idle, st_cfg, st_data} conv_state_t;

  typedef struct packed {
    logic [1:0]             sck_s;
    logic [1:0]             cs_s;
    logic [1:0]             mosi_s;
    logic                   sck_d;
    conv_state_t            state;
    logic [CNT_W-1:0]       cnt;
    logic [CHAN_BITS:0]     cfg;
    logic [RESULT_BITS-1:0] res;
    logic                   dout;
    logic                   oe;
    logic                   take;
  } conv_t;

  conv_t st_r;
  conv_t st_nxt;

  logic rise;
  logic fall;
  logic cs_n;
  logic din;

  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  assign cs_n = st_r.cs_s[1];
  assign din  = st_r.mosi_s[1];
  assign rise = st_r.sck_s[1] & ~st_r.sck_d;
  assign fall = ~st_r.sck_s[1] & st_r.sck_d;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.sck_s  = {st_r.sck_s[0], spi.sck};
    st_nxt.cs_s   = {st_r.cs_s[0], spi.select_and_powerdown_input};
    st_nxt.mosi_s = {st_r.mosi_s[0], spi.mosi};
    st_nxt.sck_d  = st_r.sck_s[1];
    st_nxt.take   = 1'b0;
    if (cs_n)
    begin
      // Raising select aborts any frame
      st_nxt.state = st_idle;
      st_nxt.oe    = 1'b0;
      st_nxt.cnt   = '0;
    end
    else
    begin
      case (st_r.state)
        st_idle:
        begin
          if (rise && din)
          begin
            st_nxt.state = st_cfg;
            st_nxt.cnt   = '0;
          end
        end
        st_cfg:
        begin
          if (rise)
          begin
            if (st_r.cnt < CFG_CLOCKS - 6'h01)
            begin
              st_nxt.cfg = {st_r.cfg[CHAN_BITS-1:0], din};
            end
            st_nxt.cnt = st_r.cnt + 6'h01;
          end
          if (fall && st_r.cnt == CFG_CLOCKS)
          begin
            // Sampling ends here; result is taken as a whole
            st_nxt.take  = 1'b1;
            st_nxt.res   = sample_value;
            st_nxt.state = st_data;
            st_nxt.oe    = 1'b1;
            st_nxt.dout  = 1'b0;
            st_nxt.cnt   = NULL_SLOT;
          end
        end
        st_data:
        begin
          if (fall)
          begin
            st_nxt.cnt = (st_r.cnt == LSBF_END) ? st_r.cnt : st_r.cnt + 6'h01;
            if (st_r.cnt < MSB_SLOT + 6'(RESULT_BITS) - 6'h01)
            begin
              // MSB first
              st_nxt.dout = st_r.res[RESULT_BITS - 1 - 32'(st_r.cnt + 6'h01 - MSB_SLOT)];
            end
            else if (st_r.cnt < LSBF_END - 6'h01)
            begin
              // LSB first, skipping the shared LSB
              st_nxt.dout = st_r.res[32'(st_r.cnt + 6'h02 - MSB_SLOT) - RESULT_BITS];
            end
            else
            begin
              st_nxt.dout = 1'b0;
            end
          end
        end
        default:
        begin
          st_nxt.state = st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_r       <= '0;
      st_r.cs_s  <= 2'h3;
      st_r.state <= st_idle;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  assign spi.miso_o    = st_r.dout;
  assign spi.miso_oe   = st_r.oe;
  assign sample_take   = st_r.take;
  assign sample_config = st_r.cfg;

endmodule : adc_converter_end
`default_nettype wire

// *** design/adc_link_pkg.sv ***
package adc_link_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int unsigned RESULT_BITS      = 12;
  localparam int unsigned CHAN_BITS        = 3;
  localparam int unsigned BYTE_BITS        = 8;
  localparam int unsigned FRAME_BYTES      = 3;
  localparam int unsigned LEAD_ZEROS       = 5;
  localparam int unsigned CNT_W            = 6;
  localparam int unsigned BIT_CNT_W        = 4;
  localparam int unsigned BYTE_CNT_W       = 2;
  // Clocks after start bit: mode, 3 channel bits, one sample clock
  localparam logic [CNT_W-1:0] CFG_CLOCKS  = 6'h05;
  // Null bit index, first MSB index, end of LSB-first repeat
  localparam logic [CNT_W-1:0] NULL_SLOT   = 6'h05;
  localparam logic [CNT_W-1:0] MSB_SLOT    = 6'h06;
  localparam logic [CNT_W-1:0] LSBF_END    = 6'h23;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ           = 20000000;
  localparam int unsigned CONV_MAX_US      = 1200;
  localparam int unsigned CONV_MAX_CYC     = (CONV_MAX_US * (CLK_HZ / 1000000));
  localparam int unsigned SCK_HALF_CYC     = 4;

  typedef enum logic [1:0] {mode_00, mode_11} spi_mode_t;

endpackage : adc_link_pkg

// *** design/adc_spi_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface adc_spi_if;
  logic sck;
  logic select_and_powerdown_input;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  assign miso = miso_oe ? miso_o : 1'b1;
  modport converter (input sck, input select_and_powerdown_input, input mosi, output miso_o, output miso_oe);
  modport host (output sck, output select_and_powerdown_input, output mosi, input miso);
endinterface : adc_spi_if
`default_nettype wire

// *** design/adc_host_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_host_end
  import adc_link_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCK_HALF_CYC
)
(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  adc_spi_if.host                     spi,
  input  wire logic                   start,
  input  wire logic                   mode_11_sel,
  input  wire logic [CHAN_BITS:0]     config_in,
  output logic                        busy,
  output logic                        done,
  output logic      [RESULT_BITS-1:0] result
);

  typedef enum logic [1:0] {h_idle, h_low, h_high, h_end} host_state_t;

  typedef struct packed {
    logic [1:0]                          miso_s;
    host_state_t                         state;
    logic                                idle_lvl;
    logic                                sck;
    logic                                cs_n;
    logic [7:0]                          div;
    logic [BYTE_BITS*FRAME_BYTES-1:0]    tx;
    logic [BYTE_BITS*FRAME_BYTES-1:0]    rx;
    logic [4:0]                          nbit;
    logic                                done;
    logic [RESULT_BITS-1:0]              res;
  } host_t;

  host_t h_r;
  host_t h_nxt;
  logic  tick;

  assign tick = (h_r.div == 8'(HALF_CYC - 1));

  always_comb
  begin
    h_nxt        = h_r;
    h_nxt.miso_s = {h_r.miso_s[0], spi.miso};
    h_nxt.done   = 1'b0;
    h_nxt.div    = tick ? 8'h00 : h_r.div + 8'h01;
    case (h_r.state)
      h_idle:
      begin
        h_nxt.div = 8'h00;
        if (start)
        begin
          h_nxt.idle_lvl = mode_11_sel;
          // Idle-high clock must fall first so the first bit gets its own rise
          h_nxt.sck      = 1'b0;
          h_nxt.cs_n     = 1'b0;
          // Five zeros, start, mode, channels
          h_nxt.tx    = {5'h00, 1'b1, config_in, 14'h0000};
          h_nxt.nbit  = 5'h00;
          h_nxt.state = h_low;
        end
      end
      h_low:
      begin
        // Clock low phase: data already set by falling edge
        if (tick)
        begin
          h_nxt.sck   = 1'b1;
          h_nxt.rx    = {h_r.rx[22:0], h_r.miso_s[1]};
          h_nxt.state = h_high;
        end
      end
      h_high:
      begin
        if (tick)
        begin
          if (h_r.nbit == 5'(BYTE_BITS * FRAME_BYTES - 1))
          begin
            h_nxt.sck   = h_r.idle_lvl;
            h_nxt.state = h_end;
          end
          else
          begin
            h_nxt.sck   = 1'b0;
            h_nxt.tx    = {h_r.tx[22:0], 1'b0};
            h_nxt.nbit  = h_r.nbit + 5'h01;
            h_nxt.state = h_low;
          end
        end
      end
      h_end:
      begin
        if (tick)
        begin
          h_nxt.cs_n  = 1'b1;
          h_nxt.done  = 1'b1;
          h_nxt.res   = h_r.rx[RESULT_BITS-1:0];
          h_nxt.state = h_idle;
        end
      end
      default:
      begin
        h_nxt.state = h_idle;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      h_r       <= '0;
      h_r.cs_n  <= 1'b1;
      h_r.state <= h_idle;
    end
    else if (clk_en)
    begin
      h_r <= h_nxt;
    end
  end

  assign spi.sck                        = h_r.sck;
  assign spi.select_and_powerdown_input = h_r.cs_n;
  assign spi.mosi                       = h_r.tx[BYTE_BITS*FRAME_BYTES-1];
  assign busy                           = (h_r.state != h_idle);
  assign done                           = h_r.done;
  assign result                         = h_r.res;

endmodule : adc_host_end
`default_nettype wire

// *** verification/adc_link_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_link_sva (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic sck,
  input  wire logic select_and_powerdown_input,
  input  wire logic mosi,
  input  wire logic miso_o,
  input  wire logic miso_oe,
  input  wire logic miso
);
  logic [5:0] rise_r;
  logic       sck_r;
  wire        cs = select_and_powerdown_input;

  // ****************************************
  // Rise counter, cleared outside frames
  // ****************************************
  always_ff @(posedge clk)
  begin
    sck_r  <= sck;
    rise_r <= (!resetn || cs) ? 6'h00 : rise_r + {5'h00, sck & ~sck_r};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_rise;
    !cs && sck && !sck_r;
  endsequence

  a_lead_zeros: assert property (s_rise ##0 rise_r < 6'h05 |-> !mosi)
    else $error("leading bit not zero");
  a_start_bit_high: assert property (s_rise ##0 rise_r == 6'h05 |-> mosi)
    else $error("start bit missing");
  a_float_early: assert property (!cs && rise_r < 6'h0b |-> !miso_oe)
    else $error("output driven too early");
  a_null_bit_low: assert property (s_rise ##0 rise_r == 6'h0b |-> miso_oe && !miso_o)
    else $error("null bit wrong");
  a_result_driven: assert property (!cs && rise_r >= 6'h0c && rise_r < 6'h18 |-> miso_oe)
    else $error("output released in result");
  a_out_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
    else $error("output changed while clock high");
  a_host_on_fall: assert property (!cs && rise_r != 6'h00 && $changed(mosi) |-> !sck)
    else $error("command changed while clock high");
  a_cs_whole_frame: assert property ($rose(cs) |-> rise_r == 6'h18)
    else $error("frame length wrong");
  a_idle_clock_rest: assert property ($rose(cs) |=> $stable(sck) [*4])
    else $error("clock moved between frames");
  a_conv_time: assert property (s_rise ##0 rise_r == 6'h0a |-> ##[1:1000] $rose(cs))
    else $error("result not clocked out in time");
endmodule : adc_link_sva
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_link_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  logic        m11 = 1'b0;
  logic        done, busy, take;
  logic [3:0]  cfg = 4'h0;
  logic [3:0]  scfg;
  logic [11:0] val = 12'h000;
  logic [11:0] res;
  logic [23:0] rx, tx;
  int          failures = 0;
  int          checks_done = 0;

  adc_spi_if spi_i ();
  adc_converter_end adc_converter_end_i (.clk(clk), .resetn(resetn), .clk_en(1'b1), .spi(spi_i.converter),
    .sample_value(val), .sample_take(take), .sample_config(scfg));
  // Wider half period keeps the converter's sync latency clear of the sampling rise
  adc_host_end #(.HALF_CYC(6)) adc_host_end_i (.clk(clk), .resetn(resetn), .clk_en(1'b1), .spi(spi_i.host),
    .start(start), .mode_11_sel(m11), .config_in(cfg), .busy(busy), .done(done), .result(res));
  adc_link_sva adc_link_sva_i (.clk(clk), .resetn(resetn), .sck(spi_i.sck),
    .select_and_powerdown_input(spi_i.select_and_powerdown_input), .mosi(spi_i.mosi),
    .miso_o(spi_i.miso_o), .miso_oe(spi_i.miso_oe), .miso(spi_i.miso));

  always #25 clk = ~clk;

  // ****************************************
  // Wire monitor and frame task
  // ****************************************
  always @(posedge spi_i.sck)
    if (!spi_i.select_and_powerdown_input)
    begin
      rx = {rx[22:0], spi_i.miso};
      tx = {tx[22:0], spi_i.mosi};
    end

  task automatic frame(input logic mode, input logic [3:0] c, input logic [11:0] v);
    int n;
    n = 0;
    m11 = mode;
    cfg = c;
    val = v;
    @(posedge clk) #5 start = 1'b1;
    @(posedge clk) #5 start = 1'b0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clk) #5;
      n++;
    end
    if (n == 1000)
    begin
      failures++;
      tally_and_finish();
    end
    `CHK(res, v)
    `CHK(rx[11:0], v)
    `CHK(rx[12], 1'b0)
    `CHK(rx[15:13], 3'h7)
    `CHK(tx[23:18], 6'h01)
    `CHK(tx[17:14], c)
    `CHK(scfg, c)
    `CHK(busy, 1'b0)
    // Let the clock rest before the next frame
    repeat (4) @(posedge clk);
  endtask : frame

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #250000;
    failures++;
    tally_and_finish();
  end

  // Back to back frames in both idle levels, extreme and mixed codes
  initial
  begin
    logic [11:0] vals [4] = '{12'hfff, 12'h000, 12'ha5c, 12'h3c1};
    repeat (3) @(posedge clk);
    #5 resetn = 1'b1;
    for (int i = 0; i < 8; i++)
      frame(i[2], 4'(i * 5 + 3), vals[i % 4]);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
